/* core/ciod_core.sv */
// ciod_core: executes control, inherent and indirect-pointer opcodes
// assumes an APB master on core_clk; opcodes arrive as register writes
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ciod_core
	import ciod_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// side effects toward the device
	output logic             watchdogKick,
	output logic             standby,
	output logic             softResetReq
);
	// ==========================================================
	// state
	logic [7:0]  acc;          // accumulator
	logic [4:0]  flags;        // timeout, powerdown, zero, dc, carry
	logic [10:0] pc;           // program counter
	logic [15:0] ptr [2];      // pointer pairs
	logic [7:0]  option;       // timer option register
	logic [7:0]  pin_direction_load [8];     // pin direction registers
	logic [7:0]  mem [128];    // data memory
	logic [10:0] stack [16];   // return stack
	logic [3:0]  sp;           // next free stack slot
	logic [1:0]  busyCnt;      // idle cycles left
	logic [13:0] lastOp;       // last accepted opcode
	logic [6:0]  memAddr;      // software window address
	// ==========================================================
	// decode results
	logic [7:0]  next_acc;
	logic [4:0]  next_flags;
	logic [10:0] next_pc;
	logic [15:0] next_ptr;
	logic        ptrWe;        // pointer update
	logic        ptrIdx;       // which pointer
	logic        exMemWe;      // execution writes memory
	logic [6:0]  exMemAddr;
	logic [7:0]  exMemData;
	logic [6:0]  readAddr;     // execution read address
	logic [1:0]  cycles;       // cost of this opcode
	logic        pushEn;
	logic        popEn;
	logic        optionWe;
	logic        trisWe;
	logic        kickEn;
	logic        sleepEn;
	logic        resetEn;
	// ==========================================================
	// helpers
	logic [13:0] op;           // opcode on the bus
	logic [10:0] pcInc;        // pc after fetch
	logic [7:0]  rdByte;       // memory at readAddr
	logic [15:0] stepPtr;      // pointer after inc/dec
	logic [15:0] stepEa;       // pre/post effective address
	logic [15:0] idxPtr;       // selected pointer plus offset
	logic [8:0]  sum9;         // add constant sum
	logic [4:0]  sumLow;       // low nibble sum
	logic [7:0]  andF;         // and file result
	logic        busy;
	logic        setupEn;      // first access cycle
	logic        regWr;        // write commit edge
	logic        opStart;      // execute commit edge
	logic        hit;          // address mapped
	logic [31:0] rdMux;
	ciod_mod_e   modeOp;

	assign op      = pwdata[13:0];
	assign pcInc   = pc + 11'h001;
	assign busy    = (busyCnt != 2'h0);
	assign setupEn = psel & penable & ~pready;
	assign regWr   = psel & penable & pready & pwrite & ~pslverr;
	assign opStart = regWr & (paddr == OFS_OPCODE);
	assign rdByte  = mem[readAddr];
	assign modeOp  = ciod_mod_e'(op[1:0]);
	// wraps naturally in 16 bits, never saturates
	assign stepPtr = (modeOp == MOD_PRE_DEC || modeOp == MOD_POST_DEC)
		? ptr[op[2]] - 16'h0001 : ptr[op[2]] + 16'h0001;
	assign stepEa  = (modeOp == MOD_PRE_INC || modeOp == MOD_PRE_DEC)
		? stepPtr : ptr[op[2]];
	assign idxPtr  = ptr[op[6]] + {{10{op[5]}}, op[5:0]};
	assign sum9    = {1'b0, acc} + {1'b0, op[7:0]};
	assign sumLow  = {1'b0, acc[3:0]} + {1'b0, op[3:0]};
	assign andF    = acc & rdByte;

	// ==========================================================
	// opcode decode and execution values
	always_comb
	begin
		next_acc   = acc;
		next_flags = flags;
		next_pc    = pcInc;
		next_ptr   = stepPtr;
		ptrWe      = 1'b0;
		ptrIdx     = op[2];
		exMemWe    = 1'b0;
		exMemAddr  = stepEa[6:0];
		exMemData  = acc;
		readAddr   = stepEa[6:0];
		cycles     = CYC_ONE;
		pushEn     = 1'b0;
		popEn      = 1'b0;
		optionWe   = 1'b0;
		trisWe     = 1'b0;
		kickEn     = 1'b0;
		sleepEn    = 1'b0;
		resetEn    = 1'b0;
		priority casez (op)
			OP_NOP:
				cycles = CYC_ONE;
			OP_SWRESET:
				resetEn = 1'b1;
			OP_RETURN, OP_IRET:
			begin
				// return pops the stack
				next_pc = stack[sp - 4'h1];
				popEn   = 1'b1;
				cycles  = CYC_TWO;
			end
			OP_CALLACC:
			begin
				// target page from pc, low byte from accumulator
				next_pc = {pc[10:8], acc};
				pushEn  = 1'b1;
				cycles  = CYC_TWO;
			end
			OP_BRACC:
			begin
				next_pc = pcInc + {3'h0, acc};
				cycles  = CYC_TWO;
			end
			OP_OPTION:
				optionWe = 1'b1;
			OP_STANDBY:
			begin
				sleepEn              = 1'b1;
				next_flags[ST_TOUT]  = 1'b1;
				next_flags[ST_PDOWN] = 1'b0;
			end
			OP_KICK:
			begin
				kickEn               = 1'b1;
				next_flags[ST_TOUT]  = 1'b1;
				next_flags[ST_PDOWN] = 1'b1;
			end
			OP_PIN_DIRECTION_LOAD:
				trisWe = 1'b1;
			OP_LDIND:
			begin
				// load through pointer, modified before or after the load by mode
				next_acc            = rdByte;
				next_flags[ST_ZERO] = (rdByte == 8'h00);
				ptrWe               = 1'b1;
				cycles              = stepEa[15] ? CYC_TWO : CYC_ONE;
			end
			OP_STIND:
			begin
				exMemWe = 1'b1;
				ptrWe   = 1'b1;
				cycles  = stepEa[15] ? CYC_TWO : CYC_ONE;
			end
			OP_ANDFILE:
			begin
				readAddr            = op[6:0];
				exMemAddr           = op[6:0];
				exMemData           = andF;
				next_flags[ST_ZERO] = (andF == 8'h00);
				// destination bit picks memory or accumulator
				if (op[7])
					exMemWe = 1'b1;
				else
					next_acc = andF;
			end
			OP_CALL:
			begin
				next_pc = op[10:0];
				pushEn  = 1'b1;
				cycles  = CYC_TWO;
			end
			OP_GOTO:
			begin
				next_pc = op[10:0];
				cycles  = CYC_TWO;
			end
			OP_RELJUMP:
			begin
				next_pc = pcInc + {{2{op[8]}}, op[8:0]};
				cycles  = CYC_TWO;
			end
			OP_PTRADD:
			begin
				// flags left alone
				ptrIdx   = op[6];
				next_ptr = idxPtr;
				ptrWe    = 1'b1;
			end
			OP_RETCONST:
			begin
				next_acc = op[7:0];
				next_pc  = stack[sp - 4'h1];
				popEn    = 1'b1;
				cycles   = CYC_TWO;
			end
			OP_ANDCONST:
			begin
				next_acc            = acc & op[7:0];
				next_flags[ST_ZERO] = ((acc & op[7:0]) == 8'h00);
			end
			OP_ADDCONST:
			begin
				next_acc             = sum9[7:0];
				next_flags[ST_CARRY] = sum9[8];
				next_flags[ST_DIGIT] = sumLow[4];
				next_flags[ST_ZERO]  = (sum9[7:0] == 8'h00);
			end
			OP_LDIDX:
			begin
				// pointer stays, offset only forms the address
				readAddr            = idxPtr[6:0];
				next_acc            = rdByte;
				next_flags[ST_ZERO] = (rdByte == 8'h00);
				cycles              = idxPtr[15] ? CYC_TWO : CYC_ONE;
			end
			OP_STIDX:
			begin
				exMemAddr = idxPtr[6:0];
				exMemWe   = 1'b1;
				cycles    = idxPtr[15] ? CYC_TWO : CYC_ONE;
			end
			default:
				// nothing changes but the pc step
				cycles = CYC_ONE;
		endcase
	end

	// ==========================================================
	// busy counter: idle cycles after each opcode
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			busyCnt <= 2'h0;
		else if (opStart)
			busyCnt <= cycles - 2'h1;
		else if (busy)
			busyCnt <= busyCnt - 2'h1;
	end

	// ==========================================================
	// accumulator
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			acc <= 8'h00;
		else if (opStart)
			acc <= next_acc;
		else if (regWr && paddr == OFS_ACC)
			acc <= pwdata[7:0];
	end

	// ==========================================================
	// status flags
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			flags <= FLAGS_RST;
		else if (opStart)
			flags <= next_flags;
		else if (regWr && paddr == OFS_STATUS)
			flags <= pwdata[4:0];
	end

	// ==========================================================
	// program counter and last opcode
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pc     <= PC_RST;
			lastOp <= 14'h0000;
		end
		else if (opStart)
		begin
			pc     <= next_pc;
			lastOp <= op;
		end
		else if (regWr && paddr == OFS_PC)
			pc <= pwdata[10:0];
	end

	// ==========================================================
	// return stack pointer, wraps at sixteen
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sp <= 4'h0;
		else if (opStart && pushEn)
			sp <= sp + 4'h1;
		else if (opStart && popEn)
			sp <= sp - 4'h1;
	end

	// return stack contents
	always_ff @(posedge core_clk)
	begin
		if (opStart && pushEn)
			stack[sp] <= pcInc;
	end

	// ==========================================================
	// pointer pairs
	for (genvar g = 0; g < 2; g++)
	begin : gPtr
		always_ff @(posedge core_clk or posedge rst)
		begin
			if (rst)
				ptr[g] <= PTR_RST;
			else if (opStart && ptrWe && ptrIdx == 1'(g))
				ptr[g] <= next_ptr;
			else if (regWr && paddr == (g == 0 ? OFS_PTR0 : OFS_PTR1))
				ptr[g] <= pwdata[15:0];
		end
	end

	// ==========================================================
	// pin direction registers
	for (genvar g = 0; g < 8; g++)
	begin : gTris
		always_ff @(posedge core_clk or posedge rst)
		begin
			if (rst)
				pin_direction_load[g] <= PIN_DIRECTION_LOAD_RST;
			else if (opStart && trisWe && op[2:0] == 3'(g))
				pin_direction_load[g] <= acc;
		end
	end

	// option register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			option <= OPTION_RST;
		else if (opStart && optionWe)
			option <= acc;
	end

	// ==========================================================
	// data memory, one write port shared by opcode and window
	always_ff @(posedge core_clk)
	begin
		if (opStart && exMemWe)
			mem[exMemAddr] <= exMemData;
		else if (regWr && paddr == OFS_MEMDATA)
			mem[memAddr] <= pwdata[7:0];
	end

	// window address
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			memAddr <= 7'h00;
		else if (regWr && paddr == OFS_MEMADDR)
			memAddr <= pwdata[6:0];
	end

	// ==========================================================
	// side-effect outputs
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			watchdogKick <= 1'b0;
			softResetReq <= 1'b0;
			standby      <= 1'b0;
		end
		else
		begin
			watchdogKick <= opStart & kickEn;
			softResetReq <= opStart & resetEn;
			// any later opcode other than standby wakes the core
			if (opStart)
				standby <= sleepEn;
		end
	end

	// ==========================================================
	// apb address decode and read mux
	always_comb
	begin
		hit   = 1'b1;
		rdMux = 32'h0000_0000;
		if (paddr[1:0] != 2'h0)
			hit = 1'b0;
		else if (paddr[7:5] == PIN_DIRECTION_LOAD_PAGE)
			rdMux = {24'h00_0000, pin_direction_load[paddr[4:2]]};
		else
		begin
			case (paddr)
				OFS_OPCODE:  rdMux = {18'h0_0000, lastOp};
				OFS_ACC:     rdMux = {24'h00_0000, acc};
				OFS_STATUS:  rdMux = {23'h00_0000, busy, 3'h0, flags};
				OFS_PC:      rdMux = {21'h00_0000, pc};
				OFS_PTR0:    rdMux = {16'h0000, ptr[0]};
				OFS_PTR1:    rdMux = {16'h0000, ptr[1]};
				OFS_OPTION:  rdMux = {24'h00_0000, option};
				OFS_MEMADDR: rdMux = {25'h000_0000, memAddr};
				OFS_MEMDATA: rdMux = {24'h00_0000, mem[memAddr]};
				default:     hit = 1'b0;
			endcase
		end
	end

	// one wait state: answer at the second access edge
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready <= setupEn;
			// unmapped, or opcode write while still busy
			pslverr <= setupEn & (~hit | (pwrite & busy & paddr == OFS_OPCODE));
			if (setupEn && !pwrite)
				prdata <= rdMux;
		end
	end
endmodule
`default_nettype wire

/* pkg/ciod_pkg.sv */
// ciod_pkg: register map, status layout, opcode patterns and types
// assumes an APB master with 32-bit data and byte addresses
`default_nettype none
package ciod_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_OPCODE  = 8'h00; // execute / last opcode
	localparam logic [7:0] OFS_ACC     = 8'h04; // accumulator
	localparam logic [7:0] OFS_STATUS  = 8'h08; // flags and busy
	localparam logic [7:0] OFS_PC      = 8'h0C; // program counter
	localparam logic [7:0] OFS_PTR0    = 8'h10; // pointer pair 0
	localparam logic [7:0] OFS_PTR1    = 8'h14; // pointer pair 1
	localparam logic [7:0] OFS_OPTION  = 8'h18; // timer option, read only
	localparam logic [7:0] OFS_MEMADDR = 8'h1C; // data memory window address
	localparam logic [7:0] OFS_MEMDATA = 8'h20; // data memory window data
	localparam logic [2:0] PIN_DIRECTION_LOAD_PAGE   = 3'h2;  // pin directions at 0x40..0x5C
	// ==========================================================
	// status bit positions
	localparam int ST_CARRY = 0;
	localparam int ST_DIGIT = 1;
	localparam int ST_ZERO  = 2;
	localparam int ST_PDOWN = 3;
	localparam int ST_TOUT  = 4;
	localparam int ST_BUSY  = 8;
	// ==========================================================
	// reset values
	localparam logic [4:0]  FLAGS_RST  = 5'h18; // timeout and powerdown high
	localparam logic [7:0]  OPTION_RST = 8'hFF;
	localparam logic [7:0]  PIN_DIRECTION_LOAD_RST   = 8'hFF;
	localparam logic [15:0] PTR_RST    = 16'h0000;
	localparam logic [10:0] PC_RST     = 11'h000;
	// ==========================================================
	// cycle costs
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	// ==========================================================
	// opcode patterns, most specific first
	localparam logic [13:0] OP_NOP      = 14'b00_0000_0000_0000;
	localparam logic [13:0] OP_SWRESET  = 14'b00_0000_0000_0001;
	localparam logic [13:0] OP_RETURN   = 14'b00_0000_0000_1000;
	localparam logic [13:0] OP_IRET     = 14'b00_0000_0000_1001;
	localparam logic [13:0] OP_CALLACC  = 14'b00_0000_0000_1010;
	localparam logic [13:0] OP_BRACC    = 14'b00_0000_0000_1011;
	localparam logic [13:0] OP_OPTION   = 14'b00_0000_0110_0010;
	localparam logic [13:0] OP_STANDBY  = 14'b00_0000_0110_0011;
	localparam logic [13:0] OP_KICK     = 14'b00_0000_0110_0100;
	localparam logic [13:0] OP_PIN_DIRECTION_LOAD     = 14'b00_0000_0110_0???;
	localparam logic [13:0] OP_LDIND    = 14'b00_0000_0001_0???;
	localparam logic [13:0] OP_STIND    = 14'b00_0000_0001_1???;
	localparam logic [13:0] OP_ANDFILE  = 14'b00_0101_????_????;
	localparam logic [13:0] OP_CALL     = 14'b10_0???_????_????;
	localparam logic [13:0] OP_GOTO     = 14'b10_1???_????_????;
	localparam logic [13:0] OP_RELJUMP  = 14'b11_001?_????_????;
	localparam logic [13:0] OP_PTRADD   = 14'b11_0001_0???_????;
	localparam logic [13:0] OP_RETCONST = 14'b11_0100_????_????;
	localparam logic [13:0] OP_ANDCONST = 14'b11_1001_????_????;
	localparam logic [13:0] OP_ADDCONST = 14'b11_1110_????_????;
	localparam logic [13:0] OP_LDIDX    = 14'b11_1111_0???_????;
	localparam logic [13:0] OP_STIDX    = 14'b11_1111_1???_????;
	// ==========================================================
	// indirect modifier field
	typedef enum logic [1:0] {
		MOD_PRE_INC  = 2'b00,
		MOD_PRE_DEC  = 2'b01,
		MOD_POST_INC = 2'b10,
		MOD_POST_DEC = 2'b11
	} ciod_mod_e;
endpackage
`default_nettype wire

/* test/ciod_core_monitor.sv */
// ciod_core_monitor: port assertions for the opcode executor
// assumes it is bound to ciod_core and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module ciod_core_monitor
	import ciod_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// apb side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// side effects
	input wire logic        watchdogKick,
	input wire logic        standby,
	input wire logic        softResetReq
);
	// ==========================================================
	// accepted opcode write and its value
	logic        opDone; // opcode write committed without error
	logic [13:0] op;     // opcode carried by that write
	assign opDone = psel && penable && pready && pwrite && paddr == OFS_OPCODE && !pslverr;
	assign op = pwdata[13:0];
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// ==========================================================
	// bus timing
	answer_wait_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("apb answer not after exactly one wait state");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	misaligned_err_a: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	// ==========================================================
	// side effects of inherent opcodes
	kick_pulse_a: assert property (opDone && op == OP_KICK |=> watchdogKick ##1 !watchdogKick)
		else $error("watchdog kick pulse missing or too long");
	kick_cause_a: assert property (watchdogKick |-> $past(opDone && op == OP_KICK))
		else $error("watchdog kick without its opcode");
	swreset_pulse_a: assert property (opDone && op == OP_SWRESET |=> softResetReq ##1 !softResetReq)
		else $error("software reset pulse missing or too long");
	swreset_cause_a: assert property (softResetReq |-> $past(opDone && op == OP_SWRESET))
		else $error("software reset without its opcode");
	standby_set_a: assert property (opDone && op == OP_STANDBY |=> standby)
		else $error("standby not entered");
	standby_clear_a: assert property (standby && opDone && op != OP_STANDBY |=> !standby)
		else $error("standby not left on next opcode");
	standby_cause_a: assert property ($rose(standby) |-> $past(opDone && op == OP_STANDBY))
		else $error("standby entered without its opcode");
	nop_quiet_a: assert property (opDone && op == OP_NOP |=> !watchdogKick && !softResetReq && !standby)
		else $error("no-op caused a side effect");
	// ==========================================================
	// main scenarios reached
	cover property (opDone && op == OP_KICK);
	cover property ($rose(standby));
	cover property (pslverr);
endmodule
bind ciod_core ciod_core_monitor i_ciod_core_monitor (.core_clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .prdata, .watchdogKick, .standby, .softResetReq);
`default_nettype wire

/* test/tb.sv */
// tb: drives ciod_core over apb and checks opcode effects by register reads
// assumes the register map and opcode patterns of ciod_pkg
`timescale 1ns/100ps
`default_nettype none
module tb
	import ciod_pkg::*;
;
	// ==========================================================
	// design ports
	logic        core_clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        watchdogKick;
	logic        standby;
	logic        softResetReq;
	// bench state
	int          mismatches;
	int          samples_checked;
	logic [31:0] rdv;                                      // last read data
	logic        err;                                      // last error flag
	int          i;
	logic [7:0]  ldv [4] = '{8'hB2, 8'h00, 8'hA1, 8'hA1}; // load value per mode
	logic [7:0]  ldp [4] = '{8'h11, 8'h0F, 8'h11, 8'h0F}; // pointer after load
	logic [7:0]  sta [4] = '{8'h21, 8'h1F, 8'h20, 8'h20}; // store address per mode
	logic [7:0]  stp [4] = '{8'h21, 8'h1F, 8'h21, 8'h1F}; // pointer after store
	ciod_core i_ciod_core (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .watchdogKick, .standby, .softResetReq);
	always #2.5 core_clk = ~core_clk;
	// ==========================================================
	// compare and bus tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one transfer, then an idle edge so psel is never reassigned at once
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			mismatches++;
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
		chk("pslverr", 32'h0, {31'h0, err});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(a, 1'b0, 32'h0);
		chk(nm, e, rdv);
	endtask
	task automatic ex(input logic [13:0] op);
		wr(OFS_OPCODE, {18'h0, op});
	endtask
	task automatic mw(input logic [7:0] a, input logic [7:0] d);
		wr(OFS_MEMADDR, {24'h0, a});
		wr(OFS_MEMDATA, {24'h0, d});
	endtask
	task automatic mr(input logic [7:0] a, input logic [7:0] e);
		wr(OFS_MEMADDR, {24'h0, a});
		rd(OFS_MEMDATA, {24'h0, e}, "mem");
	endtask
	task automatic conclude();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================================
	// watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		conclude();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		core_clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mismatches = 0;
		samples_checked = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(OFS_STATUS, 32'h18, "status");
		rd(OFS_OPTION, 32'hFF, "option");
		for (i = 0; i < 8; i++)
			rd({PIN_DIRECTION_LOAD_PAGE, 5'h00} + 8'(i * 4), 32'hFF, "pindir");
		// add and and with constants, flags and pc step
		wr(OFS_ACC, 32'h0F);
		wr(OFS_STATUS, 32'h18);
		wr(OFS_PC, 32'h010);
		ex(14'h3EF1);
		rd(OFS_ACC, 32'h00, "acc");
		rd(OFS_STATUS, 32'h1F, "status");
		rd(OFS_PC, 32'h011, "pc");
		wr(OFS_ACC, 32'hA5);
		wr(OFS_STATUS, 32'h19);
		ex(14'h395A);
		rd(OFS_STATUS, 32'h1D, "status");
		wr(OFS_ACC, 32'hF3);
		ex(14'h393C);
		rd(OFS_ACC, 32'h30, "acc");
		rd(OFS_STATUS, 32'h19, "status");
		// and with a file register, both destinations, top address
		mw(8'h05, 8'h3C);
		wr(OFS_ACC, 32'h0F);
		ex(14'h0585);
		mr(8'h05, 8'h0C);
		rd(OFS_ACC, 32'h0F, "acc");
		ex(14'h0505);
		rd(OFS_ACC, 32'h0C, "acc");
		mw(8'h7F, 8'hF0);
		wr(OFS_ACC, 32'h0F);
		ex(14'h05FF);
		mr(8'h7F, 8'h00);
		rd(OFS_STATUS, 32'h1D, "status");
		// option and pin direction loads
		wr(OFS_ACC, 32'h37);
		ex(OP_OPTION);
		rd(OFS_OPTION, 32'h37, "option");
		rd(OFS_STATUS, 32'h1D, "status");
		rd({PIN_DIRECTION_LOAD_PAGE, 5'h08}, 32'hFF, "pindir");
		for (i = 0; i < 8; i++)
			if (i < 2 || i > 4)
			begin
				wr(OFS_ACC, 32'(i) + 32'h20);
				ex(14'h0060 + 14'(i));
				rd({PIN_DIRECTION_LOAD_PAGE, 5'h00} + 8'(i * 4), 32'(i) + 32'h20, "pindir");
			end
		// standby, watchdog kick, software reset
		wr(OFS_STATUS, 32'h00);
		ex(OP_STANDBY);
		chk("standby", 32'h1, {31'h0, standby});
		rd(OFS_STATUS, 32'h10, "status");
		ex(OP_NOP);
		chk("standby", 32'h0, {31'h0, standby});
		wr(OFS_STATUS, 32'h00);
		ex(OP_KICK);
		rd(OFS_STATUS, 32'h18, "status");
		ex(OP_SWRESET);
		// pointer add with wrap both ways
		wr(OFS_PTR0, 32'hFFFE);
		wr(OFS_STATUS, 32'h07);
		ex(14'h3103);
		rd(OFS_PTR0, 32'h0001, "ptr0");
		wr(OFS_PTR1, 32'h0001);
		ex(14'h3160);
		rd(OFS_PTR1, 32'hFFE1, "ptr1");
		rd(OFS_PTR0, 32'h0001, "ptr0");
		rd(OFS_STATUS, 32'h07, "status");
		// indirect load, every modifier
		mw(8'h0F, 8'h00);
		mw(8'h10, 8'hA1);
		mw(8'h11, 8'hB2);
		for (i = 0; i < 4; i++)
		begin
			wr(OFS_PTR0, 32'h0010);
			wr(OFS_STATUS, 32'h00);
			ex(14'h0010 + 14'(i));
			rd(OFS_ACC, {24'h0, ldv[i]}, "acc");
			rd(OFS_PTR0, {24'h0, ldp[i]}, "ptr0");
			rd(OFS_STATUS, (ldv[i] == 8'h00) ? 32'h4 : 32'h0, "status");
		end
		wr(OFS_PTR1, 32'h0000);
		ex(14'h0015);
		rd(OFS_PTR1, 32'hFFFF, "ptr1");
		rd(OFS_ACC, 32'h00, "acc");
		// indirect store, every modifier
		wr(OFS_STATUS, 32'h07);
		for (i = 0; i < 4; i++)
		begin
			wr(OFS_PTR1, 32'h0020);
			wr(OFS_ACC, 32'(i) + 32'h50);
			ex(14'h001C + 14'(i));
			mr(sta[i], 8'(i) + 8'h50);
			rd(OFS_PTR1, {24'h0, stp[i]}, "ptr1");
		end
		rd(OFS_STATUS, 32'h07, "status");
		// indexed load and store with signed offsets
		mw(8'h2F, 8'h77);
		wr(OFS_PTR0, 32'h0030);
		ex(14'h3F3F);
		rd(OFS_ACC, 32'h77, "acc");
		rd(OFS_PTR0, 32'h0030, "ptr0");
		wr(OFS_ACC, 32'h6B);
		wr(OFS_PTR1, 32'h0040);
		ex(14'h3FC5);
		mr(8'h45, 8'h6B);
		rd(OFS_PTR1, 32'h0040, "ptr1");
		// control transfers
		wr(OFS_PC, 32'h100);
		wr(OFS_ACC, 32'h05);
		ex(OP_BRACC);
		rd(OFS_PC, 32'h106, "pc");
		wr(OFS_PC, 32'h123);
		wr(OFS_ACC, 32'h45);
		ex(OP_CALLACC);
		rd(OFS_PC, 32'h145, "pc");
		ex(OP_RETURN);
		rd(OFS_PC, 32'h124, "pc");
		wr(OFS_PC, 32'h010);
		ex(14'h2200);
		rd(OFS_PC, 32'h200, "pc");
		ex(14'h349C);
		rd(OFS_PC, 32'h011, "pc");
		rd(OFS_ACC, 32'h9C, "acc");
		ex(14'h2AAB);
		rd(OFS_PC, 32'h2AB, "pc");
		ex(14'h2300);
		ex(OP_IRET);
		rd(OFS_PC, 32'h2AC, "pc");
		wr(OFS_PC, 32'h050);
		ex(14'h33FE);
		rd(OFS_PC, 32'h04F, "pc");
		// unassigned opcode leaves state alone but steps the pc
		wr(OFS_ACC, 32'h5A);
		wr(OFS_PC, 32'h070);
		wr(OFS_STATUS, 32'h07);
		ex(14'h0005);
		rd(OFS_ACC, 32'h5A, "acc");
		rd(OFS_PC, 32'h071, "pc");
		rd(OFS_STATUS, 32'h07, "status");
		// refused accesses
		bus(8'h02, 1'b1, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
		bus(8'h30, 1'b0, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
		chk("prdata", 32'h0, rdv);
		conclude();
	end
endmodule
`default_nettype wire
